/* verilog/core_phase_pkg.sv */
// Constants for the phase-divided instruction pipeline
package core_phase_pkg;
  // Phase numbering within one instruction cycle
  localparam logic [1:0] PH_ONE   = 2'h0;
  localparam logic [1:0] PH_TWO   = 2'h1;
  localparam logic [1:0] PH_THREE = 2'h2;
  localparam logic [1:0] PH_FOUR  = 2'h3;
  // Widths
  localparam int PC_W   = 11;
  localparam int WORD_W = 12;
  localparam int DATA_W = 8;
  localparam int REG_W  = 5;
  // Field positions
  localparam int JMP_LSB  = 0;
  localparam int JMP_W    = 9;
  localparam int DEST_BIT = 5;
  localparam int STAT_PG_LO = 5;
  // Opcode patterns
  localparam logic [2:0] OP_JUMP      = 3'h5;
  localparam logic [5:0] OP_INC       = 6'h0A;
  localparam logic [5:0] OP_INC_SKIP  = 6'h0F;
  // Reset values
  localparam logic [WORD_W-1:0] NOP_WORD = 12'h000;
  localparam logic [PC_W-1:0]   PC_RST   = 11'h7FF;
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
endpackage : core_phase_pkg

/* verilog/phase_divider.sv */
// Divide-by-four phase generator
module phase_divider (
  input  wire logic       mclk,
  input  wire logic       rst,
  output logic [1:0]      phase,
  output logic            phase_one,
  output logic            phase_two,
  output logic            phase_three,
  output logic            phase_four
);
  logic [1:0] phase_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_r <= core_phase_pkg::PH_ONE;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign phase       = phase_r;
  assign phase_one   = (phase_r == core_phase_pkg::PH_ONE);
  assign phase_two   = (phase_r == core_phase_pkg::PH_TWO);
  assign phase_three = (phase_r == core_phase_pkg::PH_THREE);
  assign phase_four  = (phase_r == core_phase_pkg::PH_FOUR);
endmodule // phase_divider

/* verilog/core_phase_pipeline.sv */
// Fetch/execute pipeline control of the small 8-bit core
// Summary of operation
// - Oscillator divided into four phases
// - Counter increments in phase one
// - Fetched word captured in phase four
// - Fetch of next overlaps current execute
// - Decoder loads at phase one
// - Operand read phase two, register write phase one, acc write phase four
// - Counter change flushes prefetch, two cycles
// - Jump loads nine bits plus status bits
// - Increment updates zero flag, one cycle
// - Destination bit selects accumulator or register
// - Increment-skip flushes on zero, flags kept
module core_phase_pipeline (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [11:0] prog_word,
  input  wire logic [7:0]  status_in,
  input  wire logic [7:0]  reg_rdata,
  output logic [10:0]      prog_addr,
  output logic [4:0]       reg_addr,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [7:0]       reg_wdata,
  output logic [7:0]       acc,
  output logic             zero_flag,
  output logic             zero_wr,
  output logic             flush,
  output logic             phase_one,
  output logic             phase_two,
  output logic             phase_three,
  output logic             phase_four
);
  logic [1:0]  phase;
  logic [10:0] pc_r;
  logic [11:0] fetch_r;
  logic [11:0] exec_r;
  logic        squash_r;
  logic [7:0]  operand_r;
  logic [7:0]  acc_r;
  logic [7:0]  wdata_r;
  logic        wr_r;
  logic        zero_r;
  logic        zwr_r;
  logic        redirect_r;
  logic [10:0] target_r;
  logic        flush_r;
  logic [4:0]  waddr_r;

  phase_divider u_div (
    .mclk        (mclk),
    .rst         (rst),
    .phase       (phase),
    .phase_one   (phase_one),
    .phase_two   (phase_two),
    .phase_three (phase_three),
    .phase_four  (phase_four)
  );

  // Decode of the word in execution; a squashed word decodes as nothing
  wire is_jump = ~squash_r && (exec_r[11:9] == core_phase_pkg::OP_JUMP);
  wire is_inc  = ~squash_r && (exec_r[11:6] == core_phase_pkg::OP_INC);
  wire is_incs = ~squash_r && (exec_r[11:6] == core_phase_pkg::OP_INC_SKIP);
  wire dest_reg = exec_r[core_phase_pkg::DEST_BIT];
  wire [7:0] inc_val = operand_r + 8'h01;
  wire [10:0] jump_tgt = {status_in[6:5], exec_r[8:0]};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_r <= core_phase_pkg::PC_RST;
    end else if (phase_one) begin
      pc_r <= redirect_r ? target_r : pc_r + 11'h001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fetch_r <= core_phase_pkg::NOP_WORD;
    end else if (phase_four) begin
      fetch_r <= prog_word;
    end
  end

  // decoder load at phase one; flush squashes it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      exec_r   <= core_phase_pkg::NOP_WORD;
      squash_r <= 1'b1;
    end else if (phase_one) begin
      exec_r   <= fetch_r;
      squash_r <= flush_r;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      operand_r <= 8'h00;
    end else if (phase_two) begin
      operand_r <= reg_rdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_r   <= core_phase_pkg::ACC_RST;
      wdata_r <= 8'h00;
      waddr_r <= 5'h00;
      wr_r    <= 1'b0;
      zero_r  <= 1'b0;
      zwr_r   <= 1'b0;
    end else begin
      wr_r  <= 1'b0;
      zwr_r <= 1'b0;
      if (phase_four && (is_inc || is_incs)) begin
        if (dest_reg) begin
          wdata_r <= inc_val;
          waddr_r <= exec_r[4:0];
          wr_r    <= 1'b1;
        end else begin
          acc_r <= inc_val;
        end
        // Only the plain increment touches the zero flag
        if (is_inc) begin
          zero_r <= (inc_val == 8'h00);
          zwr_r  <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      redirect_r <= 1'b0;
      target_r   <= core_phase_pkg::PC_RST;
      flush_r    <= 1'b0;
    end else if (phase_four) begin
      redirect_r <= is_jump;
      target_r   <= jump_tgt;
      flush_r    <= is_jump || (is_incs && inc_val == 8'h00);
    end
  end

  assign prog_addr = pc_r;
  // The write pulse lands in phase one, before the next word enters execution,
  // and carries the index that waddr_r took from the word that produced it
  assign reg_addr  = wr_r ? waddr_r : exec_r[4:0];
  assign reg_rd    = phase_two && (is_inc || is_incs);
  assign reg_wr    = wr_r;
  assign reg_wdata = wdata_r;
  assign acc       = acc_r;
  assign zero_flag = zero_r;
  assign zero_wr   = zwr_r;
  assign flush     = flush_r;
endmodule // core_phase_pipeline

/* verif/core_phase_pipeline_props.sv */
// Port checker for the phase pipeline
module core_phase_pipeline_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [10:0] prog_addr,
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic        zero_wr,
  input wire logic        flush,
  input wire logic        phase_one,
  input wire logic        phase_two,
  input wire logic        phase_three,
  input wire logic        phase_four
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_quad;
    phase_two ##1 phase_three ##1 phase_four ##1 phase_one;
  endsequence
  property p_ring; phase_one |=> s_quad; endproperty
  property p_hot; $onehot({phase_one, phase_two, phase_three, phase_four}); endproperty
  property p_hold; !phase_one |=> $stable(prog_addr); endproperty
  property p_inc; phase_one && !flush |=> prog_addr == $past(prog_addr) + 11'h001; endproperty
  property p_rd; reg_rd |-> phase_two; endproperty
  property p_wr; reg_wr |-> phase_one && $past(reg_rd, 3) ##1 !reg_wr; endproperty
  property p_zw; zero_wr |-> phase_one ##1 !zero_wr; endproperty
  property p_wad; reg_wr |-> reg_addr == $past(reg_addr, 3); endproperty
  property p_fl; !phase_four |=> $stable(flush); endproperty
  a_ring: assert property (p_ring) else $error("phase order broken");
  a_hot: assert property (p_hot) else $error("phases not one-hot");
  a_hold: assert property (p_hold) else $error("counter moved off phase one");
  a_inc: assert property (p_inc) else $error("counter did not step");
  a_rd: assert property (p_rd) else $error("operand read off phase two");
  a_wr: assert property (p_wr) else $error("bad register write");
  a_zw: assert property (p_zw) else $error("bad zero flag update");
  a_wad: assert property (p_wad) else $error("write went to wrong register");
  a_fl: assert property (p_fl) else $error("squash changed off phase four");
endmodule // core_phase_pipeline_props

/* verif/core_mem_model.sv */
// Program memory and register file model
module core_mem_model (
  input  wire logic        mclk,
  input  wire logic [10:0] prog_addr,
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic [11:0]      prog_word,
  output logic [7:0]       status_in,
  output logic [7:0]       reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] rom [0:7];
  logic [7:0]  rf  [0:31];
  initial begin
    rom = '{12'h2A1, 12'h3C2, 12'h2A3, 12'hA05, 12'h2A4, 12'h281, 12'h2A2, 12'h000};
    foreach (rf[i]) rf[i] = 8'(i);
    rf[2] = 8'hFF;
  end
  assign prog_word = (prog_addr < 11'h008) ? rom[prog_addr[2:0]] : 12'h000;
  assign status_in = 8'h00;
  // Unread operand bus shows inverted data, never a stale value
  assign reg_rdata = reg_rd ? rf[reg_addr] : ~rf[reg_addr];
  always @(posedge mclk) if (reg_wr) rf[reg_addr] <= reg_wdata;
endmodule // core_mem_model

/* verif/tb_core_phase_pipeline.sv */
// Self-checking bench for the phase pipeline
module tb_core_phase_pipeline;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] prog_word;
  logic [10:0] prog_addr;
  logic [7:0]  status_in, reg_rdata, reg_wdata, acc;
  logic [4:0]  reg_addr;
  logic        reg_rd, reg_wr, zero_flag, zero_wr, flush;
  logic        phase_one, phase_two, phase_three, phase_four;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cycles = 0;
  core_phase_pipeline u_dut (.mclk, .rst, .prog_word, .status_in, .reg_rdata, .prog_addr,
    .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .acc, .zero_flag, .zero_wr, .flush,
    .phase_one, .phase_two, .phase_three, .phase_four);
  core_mem_model u_mem (.mclk, .prog_addr, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .prog_word, .status_in, .reg_rdata);
  always #4 mclk = ~mclk;
  task final_report;
    if (mismatches == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Program runs in about 50 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 400) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    while (prog_addr !== 11'h00A) @(negedge mclk);
    chk(u_mem.rf[1], 8'h02);
    chk(u_mem.rf[3], 8'h03);
    chk(u_mem.rf[4], 8'h04);
    chk(acc, 8'h03);
    chk(u_mem.rf[2], 8'h00);
    chk({7'h00, zero_flag}, 8'h01);
    final_report();
  end
endmodule // tb_core_phase_pipeline
bind core_phase_pipeline core_phase_pipeline_props u_props (.mclk, .rst, .prog_addr, .reg_addr, .reg_rd,
  .reg_wr, .zero_wr, .flush, .phase_one, .phase_two, .phase_three, .phase_four);
